//--- sounder_pkg.sv
// Purpose: Shared constants and types for the sounder activation control block.
// Assumes: A 50 MHz clock; times are kept in seconds and minutes.
// Notes:   Mode encodings are internal to this design.
package sounder_pkg;

    // Clock rate and the one-second time base.
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned TICK_SECONDS  = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ * TICK_SECONDS;

    // Field widths and limits.
    localparam int unsigned TONE_W        = 5;
    localparam int unsigned INTERVAL_W    = 10;
    localparam int unsigned DELAY_MIN_W   = 4;
    localparam int unsigned SEC_W         = 10;
    localparam int unsigned INTERVAL_MAX  = 600;
    localparam int unsigned PREDELAY_MAX  = 10;
    localparam int unsigned SEC_PER_MIN   = 60;

    // Reset values: tones held as number minus one, so 27 is 5'h1A.
    localparam logic [4:0] ALARM_TONE_RST = 5'h1A;
    localparam logic [4:0] EVAC_TONE_RST  = 5'h1A;
    localparam logic [4:0] CLASS_TONE_RST = 5'h0A;

    // Global output mode.
    typedef enum logic [1:0] {
        per_device_mode,
        light_only_mode,
        sound_only_mode,
        sound_and_light_mode
    } out_mode_t;

    // Evacuation action after the pre-alarm delay.
    typedef enum logic [1:0] {
        evac_sound_and_light,
        evac_sound_only,
        evac_light_only
    } evac_mode_t;

    // Configuration from the panel.
    typedef struct packed {
        logic [4:0] alarm_tone;
        logic [4:0] evac_tone;
        logic [4:0] class_tone;
        logic [9:0] off_secs;
        logic [9:0] on_secs;
        logic       swap;
        out_mode_t  out_mode;
        evac_mode_t evac_mode;
        logic       zonal;
        logic [3:0] evacuation_predelay;
        logic       repeat_enable;
    } sounder_cfg_t;

    // Command issued to every addressable sounder.
    typedef struct packed {
        logic       active;
        logic       per_device;
        logic       sound;
        logic       light;
        logic       zone_restrict;
        logic [4:0] tone;
    } sounder_cmd_t;

endpackage : sounder_pkg

//--- sounder_activation_control.sv
// Purpose: Decides how sounders are driven during alarm, evacuation and class change.
// Assumes: Events are one-cycle pulses from logic on clk; settings are static levels.
// Notes:   Tones are carried as number minus one (0 means tone 1, 31 means tone 32).
`timescale 1ns/1ps

module sounder_activation_control
    import sounder_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Configuration and events.
    input  wire sounder_cfg_t cfg,
    input  wire logic         alarm_event,
    input  wire logic         class_change_event,
    input  wire logic         net_class_change,
    input  wire logic         system_reset,
    input  wire logic         silence_alarm,
    // Outputs to sounders and panel drivers.
    output sounder_cmd_t      sounder_cmd,
    output logic              panel_sounder_on,
    output logic              in_evacuation,
    output logic              cycle_on_phase
);

    typedef enum logic [1:0] {
        st_idle,
        st_predelay,
        st_evacuate,
        st_class_change
    } run_state_t;

    localparam int unsigned TICK_W = $clog2(TICK_CYCLES_P + 1);
    // How the block behaves, for whoever picks it up next.
    //
    // Time base.
    // A free-running counter divides clk down to one pulse a second.
    // The pulse is a single clock wide and is shared by every timer.
    // Sharing it means two timers that start in the same second end
    // in the same second, which keeps the cycle and the delay aligned.
    // The cost is up to one second of jitter on the first count,
    // because a timer may start just before or just after a pulse.
    // The divider is a parameter so a test can run with a short tick.
    //
    // Run states.
    // Idle: nothing is driven and the panel outputs are off.
    // Pre-alarm: an alarm arrived and the evacuation delay is running.
    // Evacuate: the delay expired, or was zero, and full evacuation runs.
    // Class change: a local or repeated network class change is sounding.
    // A stop, from a system reset or a silence command, returns to idle
    // from every state and takes priority over any event on that edge.
    // An alarm wins over a class change that is already sounding.
    // A class change is ignored while an alarm or evacuation is running
    // so that a drill can never mask a real fire.
    // An alarm during pre-alarm or evacuation is already being served.
    //
    // Pre-alarm delay.
    // The delay is set in whole minutes and counted in seconds.
    // Settings above ten minutes are clamped to ten minutes.
    // A setting of zero skips the pre-alarm and enters evacuation at once.
    // During the delay only sounders in alarmed zones are driven,
    // whatever the common or zonal setting says.
    // The alarm tone and the global output mode apply during the delay.
    //
    // Evacuation.
    // Evacuation uses its own tone and its own output mode.
    // Sound and light, and sound only, both switch the panel outputs on.
    // Light only keeps the panel outputs off.
    // The common setting drives every sounder; the zonal one restricts
    // the command to sounders in zones that are in alarm.
    // Evacuation lasts until a stop; there is no automatic end.
    //
    // Alert and evacuation cycle.
    // Two intervals, ON and OFF, each from one to six hundred seconds.
    // Larger settings are clamped to six hundred seconds.
    // The cycle runs only when both intervals are nonzero.
    // With either interval at zero the outputs are driven continuously.
    // In the OFF interval sounders give light only and the panel is off.
    // In the ON interval the selected mode applies unchanged.
    // The swap setting decides which interval comes first.
    // The phase counter is reloaded while no alarm is being served,
    // so every new alarm starts the cycle from its first interval.
    // It is also reloaded at every change of phase.
    // The cycle runs through the pre-alarm delay as well, so the first
    // evacuation phase need not be the first phase of the cycle.
    //
    // Global output mode.
    // Per-device: each sounder follows its own configured alarm mode,
    // and the block only raises the per-device flag in the command.
    // Light only: light on the sounders, panel outputs off.
    // Sound only: sound without light, panel outputs on.
    // Sound and light: both on the sounders, panel outputs on.
    // The mode is one setting for the whole system; it is never applied
    // per zone or per device by this block.
    //
    // Class change.
    // A class change sounds with the class-change tone, panel outputs on.
    // A repeated class change from the network is taken only when
    // repetition is enabled, and it uses this panel's own tone.
    // It lasts until a stop or until an alarm takes over.
    //
    // Tones.
    // Tones are carried as the tone number minus one, so that the
    // whole range of thirty-two tones fits in five bits.
    // The tone field is passed through; this block does not check it.
    //
    // Timing of the outputs.
    // An event is taken on the rising edge at which it is high.
    // The run state changes on that edge and the outputs follow on
    // the next one, so outputs lag an event by two edges in all.
    // Every output comes straight from a flip-flop, which keeps the
    // loop drivers free of glitches from the decoding logic.
    // The cost is one clock of extra latency, far below any audible limit.
    //
    // Inputs.
    // All events and settings come from logic on clk, so none of them
    // passes a synchroniser; a source on another clock must add one.
    // Settings are expected to stay static while an alarm is served.
    // Changing an interval mid-cycle takes effect at the next reload.
    // Changing the delay while it runs does not restart the count.
    //
    // Reset.
    // The asynchronous reset clears every output and returns to idle.
    // After release the first tick comes one full tick period later.
    // The ON/OFF phase resets to ON and is reloaded before any alarm.
    //
    // Limitations.
    // Zone membership is not known here; the zone-restrict flag tells
    // the loop side to apply it.
    // Voice evacuation panels are outside this block.
    // A stop held high keeps the block idle for as long as it stands.
    // Events arriving together follow the priority given above.
    // Nothing here silences a sounder other than a stop or reset.

    run_state_t             state;
    logic [TICK_W-1:0]      tick_cnt;
    logic                   tick;
    logic [SEC_W-1:0]       phase_left;
    logic [SEC_W-1:0]       delay_left;
    logic                   on_phase;
    logic                   alarm_seen;
    logic                   cycle_enabled;
    logic                   stop_req;
    logic                   class_req;
    logic [SEC_W-1:0]       predelay_secs;
    sounder_cmd_t           next_cmd;
    logic                   next_panel;

    // Clamp a programmed interval to its documented range.
    function automatic logic [SEC_W-1:0] clamp_interval(input logic [9:0] v);
        if (v > INTERVAL_W'(INTERVAL_MAX)) begin
            clamp_interval = SEC_W'(INTERVAL_MAX);
        end else begin
            clamp_interval = v;
        end
    endfunction : clamp_interval

    assign cycle_enabled = (cfg.on_secs != 10'h000) && (cfg.off_secs != 10'h000);
    assign stop_req      = system_reset || silence_alarm;
    assign class_req     = class_change_event || (net_class_change && cfg.repeat_enable);
    // Minutes are clamped to ten, so the seconds count never exceeds 600.
    assign predelay_secs = (cfg.evacuation_predelay > DELAY_MIN_W'(PREDELAY_MAX))
                         ? SEC_W'(PREDELAY_MAX * SEC_PER_MIN)
                         : SEC_W'(cfg.evacuation_predelay) * SEC_W'(SEC_PER_MIN);

    // One-second time base shared by the cycle and the pre-alarm delay.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // Run state: idle, pre-alarm, evacuation, class change.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= st_idle;
            delay_left <= '0;
            alarm_seen <= 1'b0;
        end else if (stop_req) begin
            state      <= st_idle;
            delay_left <= '0;
            alarm_seen <= 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    if (alarm_event) begin
                        alarm_seen <= 1'b1;
                        delay_left <= predelay_secs;
                        state      <= (predelay_secs == '0) ? st_evacuate : st_predelay;
                    end else if (class_req) begin
                        state <= st_class_change;
                    end
                end
                st_predelay: begin
                    if (tick) begin
                        if (delay_left <= SEC_W'(1)) begin
                            delay_left <= '0;
                            state      <= st_evacuate;
                        end else begin
                            delay_left <= delay_left - 1'b1;
                        end
                    end
                end
                st_evacuate: begin
                    state <= st_evacuate;
                end
                st_class_change: begin
                    // An alarm takes priority over a running class change.
                    if (alarm_event) begin
                        alarm_seen <= 1'b1;
                        delay_left <= predelay_secs;
                        state      <= (predelay_secs == '0) ? st_evacuate : st_predelay;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // ON/OFF cycle; each phase change reloads the interval counter.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            on_phase   <= 1'b1;
            phase_left <= '0;
        end else if (stop_req || !alarm_seen || !cycle_enabled) begin
            on_phase   <= !cfg.swap;
            phase_left <= cfg.swap ? clamp_interval(cfg.off_secs)
                                   : clamp_interval(cfg.on_secs);
        end else if (tick) begin
            if (phase_left <= SEC_W'(1)) begin
                on_phase   <= !on_phase;
                phase_left <= on_phase ? clamp_interval(cfg.off_secs)
                                       : clamp_interval(cfg.on_secs);
            end else begin
                phase_left <= phase_left - 1'b1;
            end
        end
    end

    // Build the sounder command for the current state and phase.
    always_comb begin
        next_cmd   = '0;
        next_panel = 1'b0;
        case (state)
            st_predelay, st_evacuate: begin
                next_cmd.active = 1'b1;
                // Pre-alarm and zonal activation restrict to alarmed zones.
                next_cmd.zone_restrict = (state == st_predelay) || cfg.zonal;
                if (state == st_predelay) begin
                    next_cmd.tone = cfg.alarm_tone;
                    case (cfg.out_mode)
                        per_device_mode: next_cmd.per_device = 1'b1;
                        light_only_mode: next_cmd.light = 1'b1;
                        sound_only_mode: begin
                            next_cmd.sound = 1'b1;
                            next_panel     = 1'b1;
                        end
                        default: begin
                            next_cmd.sound = 1'b1;
                            next_cmd.light = 1'b1;
                            next_panel     = 1'b1;
                        end
                    endcase
                end else begin
                    next_cmd.tone = cfg.evac_tone;
                    case (cfg.evac_mode)
                        evac_sound_only: begin
                            next_cmd.sound = 1'b1;
                            next_panel     = 1'b1;
                        end
                        evac_light_only: next_cmd.light = 1'b1;
                        default: begin
                            next_cmd.sound = 1'b1;
                            next_cmd.light = 1'b1;
                            next_panel     = 1'b1;
                        end
                    endcase
                end
                // OFF phase overrides to light only; continuous when cycle disabled.
                if (cycle_enabled && !on_phase) begin
                    next_cmd.per_device = 1'b0;
                    next_cmd.sound      = 1'b0;
                    next_cmd.light      = 1'b1;
                    next_panel          = 1'b0;
                end
            end
            st_class_change: begin
                next_cmd.active = 1'b1;
                next_cmd.sound  = 1'b1;
                next_cmd.tone   = cfg.class_tone;
                next_panel      = 1'b1;
            end
            default: begin
                next_cmd   = '0;
                next_panel = 1'b0;
            end
        endcase
    end

    // Registered outputs.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sounder_cmd      <= '0;
            panel_sounder_on <= 1'b0;
            in_evacuation    <= 1'b0;
            cycle_on_phase   <= 1'b0;
        end else begin
            sounder_cmd      <= next_cmd;
            panel_sounder_on <= next_panel;
            in_evacuation    <= (state == st_evacuate);
            cycle_on_phase   <= on_phase && alarm_seen;
        end
    end

endmodule : sounder_activation_control

//--- sounder_field.sv
// Purpose: Model of the addressable sounders and the panel sounder drivers.
// Assumes: Commands are levels that stand until changed.
// Notes:   Per-device sounders are taken as silent and dark; the per-device flag is not modelled.
`timescale 1ns/1ps
module sounder_field
    import sounder_pkg::*;
(
    // Commands from the block.
    input  wire sounder_cmd_t sounder_cmd,
    input  wire logic         panel_sounder_on,
    // What a person on site perceives.
    output logic              audible,
    output logic              visible
);
    // A horn is heard from any addressable sounder or from the panel outputs.
    assign audible = (sounder_cmd.active & sounder_cmd.sound) | panel_sounder_on;
    assign visible = sounder_cmd.active & sounder_cmd.light;
endmodule : sounder_field

//--- sounder_activation_control_checker.sv
// Purpose: Concurrent checks on the sounder activation control ports.
// Assumes: One clock; cfg is static while a check runs.
// Notes:   Outputs lag an accepted event by two clock edges.
`timescale 1ns/1ps
module sounder_activation_control_checker
    import sounder_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic         clk,
    input wire logic         arst_n,
    // Observed inputs.
    input wire sounder_cfg_t cfg,
    input wire logic         alarm_event,
    input wire logic         class_change_event,
    input wire logic         net_class_change,
    input wire logic         system_reset,
    input wire logic         silence_alarm,
    // Observed outputs.
    input wire sounder_cmd_t sounder_cmd,
    input wire logic         panel_sounder_on,
    input wire logic         in_evacuation,
    input wire logic         cycle_on_phase
);
    // A stop wins over any event on the same edge, so events are qualified by it.
    wire logic stop = system_reset | silence_alarm;
    wire logic cyc  = (cfg.on_secs != 10'h000) && (cfg.off_secs != 10'h000);
    wire logic pre  = sounder_cmd.active && sounder_cmd.zone_restrict && !in_evacuation;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_stop_quiets: assert property (
        stop |-> ##2 (!sounder_cmd.active && !panel_sounder_on))
        else $error("Sounders still driven after stop");
    chk_idle_dark: assert property (
        !sounder_cmd.active |-> !panel_sounder_on && !in_evacuation)
        else $error("Panel driven while idle");
    chk_off_light: assert property (
        in_evacuation && cyc && !cycle_on_phase
        |-> sounder_cmd.light && !sounder_cmd.sound && !panel_sounder_on)
        else $error("OFF phase not light only");
    chk_evac_entry: assert property (
        alarm_event && !stop && cfg.evacuation_predelay == 4'h0 && !sounder_cmd.active
        |-> ##2 (in_evacuation && sounder_cmd.tone == cfg.evac_tone
                 && sounder_cmd.zone_restrict == cfg.zonal))
        else $error("Evacuation not entered at once");
    chk_prealarm_zone: assert property (
        alarm_event && !stop && cfg.evacuation_predelay != 4'h0 && !sounder_cmd.active
        |-> ##2 (pre && sounder_cmd.tone == cfg.alarm_tone))
        else $error("Pre-alarm not zone restricted");
    chk_evac_mode: assert property (
        in_evacuation && (!cyc || cycle_on_phase)
        |-> sounder_cmd.sound == (cfg.evac_mode != evac_light_only)
            && sounder_cmd.light == (cfg.evac_mode != evac_sound_only)
            && panel_sounder_on == (cfg.evac_mode != evac_light_only))
        else $error("Evacuation mode wrong");
    chk_global_mode: assert property (
        pre && !cyc && cfg.out_mode != per_device_mode
        |-> sounder_cmd.sound == (cfg.out_mode != light_only_mode)
            && sounder_cmd.light == (cfg.out_mode != sound_only_mode)
            && panel_sounder_on == sounder_cmd.sound)
        else $error("Global mode wrong");
    chk_per_device: assert property (
        pre && !cyc |-> sounder_cmd.per_device == (cfg.out_mode == per_device_mode))
        else $error("Per-device flag wrong");
    chk_class_tone: assert property (
        sounder_cmd.active && !in_evacuation && !sounder_cmd.zone_restrict
        |-> sounder_cmd.tone == cfg.class_tone && sounder_cmd.sound && panel_sounder_on)
        else $error("Class change drive wrong");
endmodule : sounder_activation_control_checker

bind sounder_activation_control sounder_activation_control_checker #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
) chk_u (
    .clk(clk), .arst_n(arst_n), .cfg(cfg), .alarm_event(alarm_event),
    .class_change_event(class_change_event), .net_class_change(net_class_change),
    .system_reset(system_reset), .silence_alarm(silence_alarm),
    .sounder_cmd(sounder_cmd), .panel_sounder_on(panel_sounder_on),
    .in_evacuation(in_evacuation), .cycle_on_phase(cycle_on_phase)
);

//--- tb_sounder_activation_control.sv
// Purpose: Self-checking bench for sounder activation control.
// Assumes: A one-second tick of ten clocks; events are one-clock pulses.
// Notes:   Tones are carried as number minus one.
`timescale 1ns/1ps
module tb_sounder_activation_control;
    import sounder_pkg::*;
    localparam int unsigned TK = 10;
    logic         clk;
    logic         arst_n;
    sounder_cfg_t cfg;
    logic [4:0]   ev;
    sounder_cmd_t c;
    logic         pnl;
    logic         evac;
    logic         onp;
    logic         audible;
    logic         visible;
    int           failures;
    int           compares;
    int           n;

    sounder_activation_control #(.TICK_CYCLES_P(TK)) dut_u (
        .clk(clk), .arst_n(arst_n), .cfg(cfg), .alarm_event(ev[0]),
        .class_change_event(ev[1]), .net_class_change(ev[2]), .system_reset(ev[3]),
        .silence_alarm(ev[4]), .sounder_cmd(c), .panel_sounder_on(pnl),
        .in_evacuation(evac), .cycle_on_phase(onp));
    sounder_field field_u (.sounder_cmd(c), .panel_sounder_on(pnl), .audible(audible),
        .visible(visible));

    // Clock of 20 ns.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compare and count; a mismatch is reported at once.
    task automatic chk(input logic [9:0] s, input logic [9:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // One-clock event pulse, then wait until its answer stands.
    task automatic go(input int i);
        @(negedge clk) ev = 5'h01 << i;
        @(negedge clk) ev = 5'h00;
        repeat (2) @(negedge clk);
    endtask : go

    // Clocks until the cycle phase changes, bounded so a stuck phase cannot hang.
    task automatic run_len(output int k);
        logic lv;
        lv = onp;
        k = 0;
        while (onp === lv && k < 1000) begin
            @(negedge clk);
            k++;
        end
    endtask : run_len

    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    // The sequence needs some 870 clocks; allow over eleven times that.
    initial begin
        #200_000;
        failures++;
        end_sim();
    end

    initial begin
        failures = 0;
        compares = 0;
        arst_n = 1'b0;
        ev = 5'h00;
        cfg = '{5'h1A, 5'h05, 5'h0A, 10'h000, 10'h000, 1'b0, per_device_mode,
                evac_sound_and_light, 1'b0, 4'h1, 1'b0};
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        chk({c.active, pnl, evac}, 3'h0);
        // Pre-alarm in each global mode: alarmed zones only, alarm tone.
        for (int m = 0; m < 4; m++) begin
            cfg.out_mode = out_mode_t'(m);
            go(0);
            chk({c.zone_restrict, evac, c.tone}, {2'b10, 5'h1A});
            if (m == 0) chk(c.per_device, 1'b1);
            else chk({c.sound, c.light, pnl}, m == 1 ? 3'b010 : m == 2 ? 3'b101 : 3'b111);
            go(4);
            chk({c.active, pnl}, 2'b00);
        end
        // A one-minute pre-alarm ends in evacuation, not earlier.
        go(0);
        repeat (580) @(negedge clk);
        chk(evac, 1'b0);
        repeat (40) @(negedge clk);
        chk({evac, c.tone}, {1'b1, 5'h05});
        go(3);
        // Immediate evacuation in each evacuation mode, common and zonal.
        cfg.evacuation_predelay = 4'h0;
        for (int e = 0; e < 3; e++) begin
            cfg.evac_mode = evac_mode_t'(e);
            cfg.zonal = e[0];
            go(0);
            chk({evac, c.sound, c.light, pnl}, {1'b1, e != 2, e != 1, e != 2});
            chk(c.zone_restrict, cfg.zonal);
            go(e == 1 ? 3 : 4);
        end
        // Two seconds on and three off, ON first, then OFF first.
        cfg.evac_mode = evac_sound_and_light;
        cfg.on_secs = 10'h002;
        cfg.off_secs = 10'h003;
        go(0);
        chk(onp, 1'b1);
        run_len(n);
        chk({c.sound, c.light, pnl, audible, visible}, 5'b01001);
        run_len(n);
        chk(n, 3 * TK);
        run_len(n);
        chk(n, 2 * TK);
        go(4);
        cfg.swap = 1'b1;
        go(0);
        chk(onp, 1'b0);
        go(3);
        // A zero OFF time leaves sounders on; class change is then refused.
        cfg.off_secs = 10'h000;
        go(0);
        repeat (60) @(negedge clk);
        chk({c.sound, pnl, audible}, 3'b111);
        go(1);
        chk(c.tone, 5'h05);
        go(4);
        // Local class change, then network repetition off and on.
        go(1);
        chk({c.active, c.sound, pnl, c.tone}, {3'b111, 5'h0A});
        go(3);
        go(2);
        chk(c.active, 1'b0);
        cfg.repeat_enable = 1'b1;
        cfg.class_tone = 5'h03;
        go(2);
        chk({c.active, c.tone}, {1'b1, 5'h03});
        go(4);
        end_sim();
    end
endmodule : tb_sounder_activation_control
